// ---- src/status_report_defines.vh ----
// Constants for the instrument status reporting block.
// Assumes inclusion by bare name from the design files.
`ifndef STATUS_REPORT_DEFINES_VH
`define STATUS_REPORT_DEFINES_VH

// Command codes on the command port.
`define CMD_W                4
`define CMD_ESR_QUERY        4'h0
`define CMD_ESE_SET          4'h1
`define CMD_ESE_QUERY        4'h2
`define CMD_STB_QUERY        4'h3
`define CMD_OPER_COND_QUERY  4'h4
`define CMD_OPER_EVENT_QUERY 4'h5
`define CMD_QUES_COND_QUERY  4'h6
`define CMD_QUES_EVENT_QUERY 4'h7
`define CMD_ERR_QUERY        4'h8
`define CMD_OPC_SET          4'h9

// Register widths.
`define BYTE_W               8
`define WORD_W               16
`define BCD_W                20

// Standard event and status byte bit positions.
`define ESR_OPC_BIT          0
`define ESR_DEV_ERR_BIT      3
`define STB_EAV_BIT          2
`define STB_ESB_BIT          5

// Operation register bit positions.
`define OPER_MEAS_BIT        4
`define OPER_LOG_BIT         10

// Questionable register bit positions.
`define QUES_CC_BIT          0
`define QUES_CV_BIT          1
`define QUES_OPP_BIT         3
`define QUES_TEMP_BIT        4
`define QUES_CAL_BIT         8
`define QUES_OVP_BIT         9
`define QUES_FUSE_BIT        10
`define QUES_SENSE_BIT       13
`define QUES_SENSE_TRIP_BIT  14
`define MSB_BIT              15

// Reset values.
`define BYTE_RESET           8'h00
`define WORD_RESET           16'h0000
`define BCD_RESET            20'h00000

// Error queue geometry and the no-error code.
`define ERRQ_AW              4
`define ERRQ_DEPTH           16
`define ERR_NONE_CODE        16'h0000

`endif

// ---- src/error_queue_mem.v ----
// Error queue storage: one write port, one read port with registered data.
// Assumes the caller keeps the pointers and never writes when the queue is full.
`include "status_report_defines.vh"

module error_queue_mem (
    // Clock.
    input  wire                   mclk_in,
    // Write port.
    input  wire                   wr_en_in,
    input  wire [`ERRQ_AW-1:0]    wr_addr_in,
    input  wire [`WORD_W-1:0]     wr_data_in,
    // Read port.
    input  wire [`ERRQ_AW-1:0]    rd_addr_in,
    output reg  [`WORD_W-1:0]     rd_data_out
);

    reg [`WORD_W-1:0] mem_q [0:`ERRQ_DEPTH-1];

    always @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_q[rd_addr_in];
    end

endmodule // error_queue_mem

// ---- src/instrument_status_reporting.v ----
// Status reporting logic: standard event, operation and questionable registers,
// status byte, error queue and decimal read-back, driven by a command port.
// Assumes commands and condition inputs are synchronous to mclk_in.
`include "status_report_defines.vh"

// Overview of operation
// - Enabled event rising sets summary bit.
// - Event enable mask settable and queryable.
// - Standard event register latches, query returns it.
// - Condition shows now, event since read.
// - Operation bit 4 on new measurement.
// - Operation bit 10 while logging enabled.
// - Questionable bit 0 in current regulation.
// - Questionable bit 1 in voltage regulation.
// - Questionable bit 3 on power trip.
// - Questionable bit 4 on over-temperature.
// - Questionable bit 8 while calibration_active.
// - Questionable bit 9 on overvoltage trip.
// - Questionable bit 10 on fuse trip.
// - Questionable bit 13 while remote sensing.
// - Questionable bit 14 on sense trip.
// - Bit 15 of both registers reads zero.
// - Eight-bit byte registers, sixteen-bit status registers.
// - Query returns sum of binary bit weights.
// - Error appends entry; query pops one.
// - Empty queue answers code zero, no error.
// - Reading event part clears it.
// - Unused bit positions read zero.
// - Operation complete set when commands finished.
module instrument_status_reporting (
    // Clock and reset.
    input  wire                   mclk_in,
    input  wire                   rst_in,
    // Command port.
    input  wire                   cmd_valid_in,
    input  wire [`CMD_W-1:0]      cmd_code_in,
    input  wire [`BYTE_W-1:0]     cmd_data_in,
    // Command execution state.
    input  wire                   exec_idle_in,
    // Standard event sources, one-cycle pulses.
    input  wire [`BYTE_W-1:0]     std_event_in,
    // Operation conditions.
    input  wire                   new_measurement_flag_in,
    input  wire                   logging_enabled_in,
    // Questionable conditions.
    input  wire                   current_regulation_mode_in,
    input  wire                   voltage_regulation_mode_in,
    input  wire                   power_limit_trip_in,
    input  wire                   overtemp_detected_in,
    input  wire                   calibration_active_in,
    input  wire                   overvoltage_trip_in,
    input  wire                   fuse_trip_in,
    input  wire                   remote_sense_enabled_in,
    input  wire                   sense_trip_in,
    // Error reports.
    input  wire                   err_push_in,
    input  wire [`WORD_W-1:0]     err_code_in,
    // Response port.
    output reg                    resp_valid_out,
    output reg  [`WORD_W-1:0]     resp_value_out,
    output reg  [`BCD_W-1:0]      resp_bcd_out,
    output reg                    resp_no_error_out,
    // Live status.
    output reg  [`BYTE_W-1:0]     status_byte_out,
    output reg  [`WORD_W-1:0]     operation_activity_status_out,
    output reg  [`WORD_W-1:0]     questionable_condition_status_out
);

    // Converts a binary value to five decimal digits by shift and add-three.
    function [`BCD_W-1:0] to_decimal;
        input [`WORD_W-1:0] bin;
        integer i;
        integer k;
        reg [`BCD_W+`WORD_W-1:0] s;
        begin
            s = {{`BCD_W{1'b0}}, bin};
            for (i = 0; i < `WORD_W; i = i + 1) begin
                for (k = 0; k < 5; k = k + 1) begin
                    if (s[`WORD_W+4*k +: 4] >= 4'h5) begin
                        s[`WORD_W+4*k +: 4] = s[`WORD_W+4*k +: 4] + 4'h3;
                    end
                end
                s = {s[`BCD_W+`WORD_W-2:0], 1'b0};
            end
            to_decimal = s[`BCD_W+`WORD_W-1:`WORD_W];
        end
    endfunction

    reg  [`BYTE_W-1:0]   esr_q;
    reg  [`BYTE_W-1:0]   esr_d;
    reg  [`BYTE_W-1:0]   ese_q;
    reg                  opc_pend_q;
    reg  [`WORD_W-1:0]   oper_cond_q;
    reg  [`WORD_W-1:0]   oper_event_q;
    reg  [`WORD_W-1:0]   ques_cond_q;
    reg  [`WORD_W-1:0]   ques_event_q;
    reg  [`ERRQ_AW:0]    wr_ptr_q;
    reg  [`ERRQ_AW:0]    rd_ptr_q;
    reg                  stage_valid_q;
    reg  [`CMD_W-1:0]    stage_cmd_q;
    reg  [`WORD_W-1:0]   stage_value_q;
    reg                  stage_empty_q;
    reg  [`WORD_W-1:0]   sel_value;
    wire [`WORD_W-1:0]   err_head;
    wire [`WORD_W-1:0]   oper_cond_d;
    wire [`WORD_W-1:0]   ques_cond_d;
    wire [`BYTE_W-1:0]   esr_set;
    wire                 q_empty;
    wire                 q_full;
    wire                 do_push;
    wire                 do_pop;
    wire                 opc_done;
    wire                 rd_esr;
    wire                 rd_oper_ev;
    wire                 rd_ques_ev;
    wire [`WORD_W-1:0]   oper_rise;
    wire [`WORD_W-1:0]   ques_rise;
    genvar               g;

    // Condition parts; unused positions and bit 15 tied to zero.
    assign oper_cond_d = {1'b0, 4'h0, logging_enabled_in, 5'h00,
                          new_measurement_flag_in, 4'h0};
    assign ques_cond_d = {1'b0, sense_trip_in, remote_sense_enabled_in,
                          2'b00, fuse_trip_in, overvoltage_trip_in,
                          calibration_active_in, 3'h0,
                          overtemp_detected_in, power_limit_trip_in,
                          1'b0, voltage_regulation_mode_in,
                          current_regulation_mode_in};

    // Rising edges of the condition parts, one detector per bit.
    generate
        for (g = 0; g < `WORD_W; g = g + 1) begin : g_rise
            assign oper_rise[g] = oper_cond_d[g] && !oper_cond_q[g];
            assign ques_rise[g] = ques_cond_d[g] && !ques_cond_q[g];
        end
    endgenerate

    // Queue state.
    assign q_empty  = (wr_ptr_q == rd_ptr_q);
    assign q_full   = (wr_ptr_q[`ERRQ_AW] != rd_ptr_q[`ERRQ_AW]) &&
                      (wr_ptr_q[`ERRQ_AW-1:0] == rd_ptr_q[`ERRQ_AW-1:0]);
    assign do_push  = err_push_in && !q_full;
    assign do_pop   = cmd_valid_in && (cmd_code_in == `CMD_ERR_QUERY) && !q_empty;

    // Read strobes of the event parts.
    assign rd_esr     = cmd_valid_in && (cmd_code_in == `CMD_ESR_QUERY);
    assign rd_oper_ev = cmd_valid_in && (cmd_code_in == `CMD_OPER_EVENT_QUERY);
    assign rd_ques_ev = cmd_valid_in && (cmd_code_in == `CMD_QUES_EVENT_QUERY);

    // Operation complete fires once earlier commands have finished.
    assign opc_done = opc_pend_q && exec_idle_in;

    // Standard event sources; a lost error report flags a device error.
    assign esr_set = std_event_in |
                     ({{(`BYTE_W-1){1'b0}}, opc_done} << `ESR_OPC_BIT) |
                     ({{(`BYTE_W-1){1'b0}}, err_push_in && q_full} << `ESR_DEV_ERR_BIT);

    // Event latches; a new event in the read cycle survives the clear.
    always @* begin
        esr_d = (rd_esr ? `BYTE_RESET : esr_q) | esr_set;
    end

    // Value selected for the query taken this cycle.
    always @* begin
        case (cmd_code_in)
            `CMD_ESR_QUERY:        sel_value = {8'h00, esr_q};
            `CMD_ESE_QUERY:        sel_value = {8'h00, ese_q};
            `CMD_STB_QUERY:        sel_value = {8'h00, status_byte_out};
            `CMD_OPER_COND_QUERY:  sel_value = oper_cond_q;
            `CMD_OPER_EVENT_QUERY: sel_value = oper_event_q;
            `CMD_QUES_COND_QUERY:  sel_value = ques_cond_q;
            `CMD_QUES_EVENT_QUERY: sel_value = ques_event_q;
            default:               sel_value = `WORD_RESET;
        endcase
    end

    error_queue_mem u_errq (
        .mclk_in     (mclk_in),
        .wr_en_in    (do_push),
        .wr_addr_in  (wr_ptr_q[`ERRQ_AW-1:0]),
        .wr_data_in  (err_code_in),
        .rd_addr_in  (rd_ptr_q[`ERRQ_AW-1:0]),
        .rd_data_out (err_head)
    );

    // Enable mask and pending operation complete.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            ese_q      <= `BYTE_RESET;
            opc_pend_q <= 1'b0;
        end else begin
            if (cmd_valid_in && (cmd_code_in == `CMD_ESE_SET)) begin
                ese_q <= cmd_data_in;
            end
            if (cmd_valid_in && (cmd_code_in == `CMD_OPC_SET)) begin
                opc_pend_q <= 1'b1;
            end else if (opc_done) begin
                opc_pend_q <= 1'b0;
            end
        end
    end

    // Operation event part; a rise in the read cycle survives the clear.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            oper_event_q <= `WORD_RESET;
        end else begin
            oper_event_q <= (rd_oper_ev ? `WORD_RESET : oper_event_q) | oper_rise;
        end
    end

    // Questionable event part; a rise in the read cycle survives the clear.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            ques_event_q <= `WORD_RESET;
        end else begin
            ques_event_q <= (rd_ques_ev ? `WORD_RESET : ques_event_q) | ques_rise;
        end
    end

    // Standard event register, condition parts and error queue pointers.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            esr_q        <= `BYTE_RESET;
            oper_cond_q  <= `WORD_RESET;
            ques_cond_q  <= `WORD_RESET;
            wr_ptr_q     <= {(`ERRQ_AW+1){1'b0}};
            rd_ptr_q     <= {(`ERRQ_AW+1){1'b0}};
        end else begin
            esr_q        <= esr_d;
            oper_cond_q  <= oper_cond_d;
            ques_cond_q  <= ques_cond_d;
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // Status byte: summary of enabled events and error queue not empty.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            status_byte_out <= `BYTE_RESET;
        end else begin
            status_byte_out <= `BYTE_RESET;
            status_byte_out[`STB_ESB_BIT] <= |(esr_d & ese_q);
            status_byte_out[`STB_EAV_BIT] <= !q_empty || do_push;
        end
    end

    // Live condition outputs.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            operation_activity_status_out    <= `WORD_RESET;
            questionable_condition_status_out <= `WORD_RESET;
        end else begin
            operation_activity_status_out    <= oper_cond_d;
            questionable_condition_status_out <= ques_cond_d;
        end
    end

    // First response stage waits for the queue head read.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            stage_valid_q <= 1'b0;
            stage_cmd_q   <= `CMD_ESR_QUERY;
            stage_value_q <= `WORD_RESET;
            stage_empty_q <= 1'b0;
        end else begin
            stage_valid_q <= cmd_valid_in && (cmd_code_in != `CMD_ESE_SET) &&
                             (cmd_code_in != `CMD_OPC_SET);
            stage_cmd_q   <= cmd_code_in;
            stage_value_q <= sel_value;
            stage_empty_q <= q_empty;
        end
    end

    // Second response stage: binary value and its decimal digits; error queries get zero digits.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            resp_valid_out    <= 1'b0;
            resp_value_out    <= `WORD_RESET;
            resp_bcd_out      <= `BCD_RESET;
            resp_no_error_out <= 1'b0;
        end else begin
            resp_valid_out <= stage_valid_q;
            if (stage_valid_q) begin
                if (stage_cmd_q == `CMD_ERR_QUERY) begin
                    resp_value_out    <= stage_empty_q ? `ERR_NONE_CODE : err_head;
                    resp_bcd_out      <= `BCD_RESET;
                    resp_no_error_out <= stage_empty_q;
                end else begin
                    resp_value_out    <= stage_value_q;
                    resp_bcd_out      <= to_decimal(stage_value_q);
                    resp_no_error_out <= 1'b0;
                end
            end
        end
    end

endmodule // instrument_status_reporting

// ---- testbench/status_report_asserts.sv ----
// Checker for the status reporting block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
module status_report_asserts (
    input logic        mclk_in, rst_in, cmd_valid_in, err_push_in,
    input logic [3:0]  cmd_code_in,
    input logic        new_measurement_flag_in, logging_enabled_in,
    input logic        current_regulation_mode_in, voltage_regulation_mode_in,
    input logic        power_limit_trip_in, overtemp_detected_in, calibration_active_in,
    input logic        overvoltage_trip_in, fuse_trip_in, remote_sense_enabled_in,
    input logic        sense_trip_in, resp_valid_out, resp_no_error_out,
    input logic [15:0] resp_value_out,
    input logic [7:0]  status_byte_out,
    input logic [15:0] operation_activity_status_out,
    input logic [15:0] questionable_condition_status_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    wire         query = cmd_valid_in && cmd_code_in != 4'h1 && cmd_code_in != 4'h9;
    logic [15:0] oper_exp;
    logic [15:0] ques_exp;
    // Condition parts show the inputs of the previous cycle.
    always @(posedge mclk_in) begin
        oper_exp <= {5'h00, logging_enabled_in, 5'h00, new_measurement_flag_in, 4'h0};
        ques_exp <= {1'b0, sense_trip_in, remote_sense_enabled_in, 2'b00, fuse_trip_in,
                     overvoltage_trip_in, calibration_active_in, 3'b000, overtemp_detected_in,
                     power_limit_trip_in, 1'b0, voltage_regulation_mode_in,
                     current_regulation_mode_in};
    end
    a_resp_after_two: assert property (query |-> ##2 resp_valid_out)
        else $error("query without a response two cycles later");
    a_resp_has_cause: assert property (resp_valid_out |-> $past(cmd_valid_in, 2))
        else $error("response without an earlier query");
    a_set_silent: assert property (cmd_valid_in && !query |-> ##2 !resp_valid_out)
        else $error("set command produced a response");
    a_oper_follow: assert property (!$past(rst_in) |-> operation_activity_status_out == oper_exp)
        else $error("operation condition differs from its inputs");
    a_ques_follow: assert property (!$past(rst_in) |-> questionable_condition_status_out == ques_exp)
        else $error("questionable condition differs from its inputs");
    a_stb_unused: assert property ((status_byte_out & 8'hDB) == 8'h00)
        else $error("unused status byte bit set");
    a_err_flag: assert property (err_push_in |=> status_byte_out[2])
        else $error("queue flag low after an error push");
    a_empty_answer: assert property (resp_valid_out && resp_no_error_out |-> resp_value_out == 16'h0000 && $past(cmd_code_in, 2) == 4'h8)
        else $error("no-error answer with a nonzero code");
    c_empty: cover property (resp_valid_out && resp_no_error_out);
    c_summary: cover property ($rose(status_byte_out[5]));
    c_queue: cover property (err_push_in ##1 status_byte_out[2]);
endmodule // status_report_asserts

bind instrument_status_reporting status_report_asserts u_chk (.*);

// ---- testbench/remote_controller.sv ----
// Remote controller model: issues commands and collects the answers.
// Assumes the block takes a command at the rising edge after it is raised.
module remote_controller (
    input  logic        mclk_in,
    input  logic        resp_valid_in,
    input  logic [15:0] resp_value_in,
    input  logic [19:0] resp_bcd_in,
    input  logic        resp_no_error_in,
    output logic        cmd_valid_out,
    output logic [3:0]  cmd_code_out,
    output logic [7:0]  cmd_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 4'hF;
        cmd_data_out = 8'h00;
    end
    // Sends one command for one cycle; released lines show the inverse value.
    task automatic send(input logic [3:0] code, input logic [7:0] data);
        @(negedge mclk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        cmd_data_out = data;
        @(negedge mclk_in);
        cmd_valid_out = 1'b0;
        cmd_code_out = ~code;
        cmd_data_out = ~data;
    endtask
    // Sends a query and waits a bounded time for its answer.
    task automatic ask(input logic [3:0] code, output logic [15:0] v, output logic [19:0] b,
                       output logic ne, output logic ok);
        ok = 1'b0;
        send(code, 8'h00);
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge mclk_in);
            if (resp_valid_in === 1'b1) begin
                v = resp_value_in;
                b = resp_bcd_in;
                ne = resp_no_error_in;
                ok = 1'b1;
            end
        end
    endtask
endmodule // remote_controller

// ---- testbench/tb.sv ----
// Testbench for the status reporting block: commands, conditions, events, errors.
// Assumes the remote controller model and the bound checker.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        exec_idle_in = 1'b1;
    logic        err_push_in = 1'b0;
    logic [7:0]  std_event_in = 8'h00;
    logic [15:0] err_code_in = 16'h0000;
    logic [10:0] cond = 11'h000;
    wire         cmd_valid_in, resp_valid_out, resp_no_error_out;
    wire  [3:0]  cmd_code_in;
    wire  [7:0]  cmd_data_in, status_byte_out;
    wire  [15:0] resp_value_out, operation_activity_status_out;
    wire  [15:0] questionable_condition_status_out;
    wire  [19:0] resp_bcd_out;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          qbit [9] = '{0, 1, 3, 4, 8, 9, 10, 13, 14};
    logic [3:0]  rcode [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC};

    always #2.5 mclk_in = ~mclk_in;

    instrument_status_reporting DUT (
        .new_measurement_flag_in(cond[0]), .logging_enabled_in(cond[1]),
        .current_regulation_mode_in(cond[2]), .voltage_regulation_mode_in(cond[3]),
        .power_limit_trip_in(cond[4]), .overtemp_detected_in(cond[5]),
        .calibration_active_in(cond[6]), .overvoltage_trip_in(cond[7]),
        .fuse_trip_in(cond[8]), .remote_sense_enabled_in(cond[9]), .sense_trip_in(cond[10]),
        .*
    );
    remote_controller ctl (
        .mclk_in(mclk_in), .resp_valid_in(resp_valid_out), .resp_value_in(resp_value_out),
        .resp_bcd_in(resp_bcd_out), .resp_no_error_in(resp_no_error_out),
        .cmd_valid_out(cmd_valid_in), .cmd_code_out(cmd_code_in), .cmd_data_out(cmd_data_in)
    );

    function automatic logic [19:0] dec(input logic [15:0] v);
        int x;
        x = v;
        dec = 20'h00000;
        for (int i = 0; i < 5; i++) begin
            dec[i*4 +: 4] = 4'(x % 10);
            x = x / 10;
        end
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic q(input string what, input logic [3:0] code, input logic [15:0] exp,
                     input logic ne = 1'b0);
        logic [15:0] v;
        logic [19:0] b;
        logic        n, ok;
        ctl.ask(code, v, b, n, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %s expected response seen none", what);
            print_verdict();
        end else begin
            check(what, v, exp);
            check({what, " decimal"}, b, code == 4'h8 ? 20'h00000 : dec(exp));
            check({what, " empty flag"}, n, ne);
        end
    endtask
    task automatic pulse(input logic [7:0] e, input logic p, input logic [15:0] c);
        @(negedge mclk_in);
        std_event_in = e;
        err_push_in = p;
        err_code_in = c;
        @(negedge mclk_in);
        std_event_in = 8'h00;
        err_push_in = 1'b0;
        err_code_in = ~c;
        @(negedge mclk_in);
    endtask

    initial begin
        repeat (16) @(negedge mclk_in);
        rst_in = 1'b0;
        foreach (rcode[i]) q("reset value", rcode[i], 16'h0000);
        q("empty queue", 4'h8, 16'h0000, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            cond[i+2] = 1'b1;
            @(negedge mclk_in);
            check("live questionable", questionable_condition_status_out, 16'h1 << qbit[i]);
            q("questionable condition", 4'h6, 16'h1 << qbit[i]);
            cond[i+2] = 1'b0;
        end
        q("questionable event", 4'h7, 16'h671B);
        q("questionable event reread", 4'h7, 16'h0000);
        cond[10:2] = 9'h1FF;
        q("all questionable", 4'h6, 16'h671B);
        cond = 11'h003;
        @(negedge mclk_in);
        cond[0] = 1'b0;
        q("operation condition", 4'h4, 16'h0400);
        q("operation event", 4'h5, 16'h0410);
        q("operation event reread", 4'h5, 16'h0000);
        cond[1] = 1'b0;
        q("logging off", 4'h4, 16'h0000);
        $display("test conditions done");
        ctl.send(4'h1, 8'h04);
        q("event mask", 4'h2, 16'h0004);
        pulse(8'h02, 1'b0, 16'h0000);
        check("summary unmasked", status_byte_out[5], 1'b0);
        pulse(8'h04, 1'b0, 16'h0000);
        check("summary masked", status_byte_out[5], 1'b1);
        q("status byte", 4'h3, 16'h0020);
        q("event register", 4'h0, 16'h0006);
        q("event register reread", 4'h0, 16'h0000);
        q("status byte cleared", 4'h3, 16'h0000);
        ctl.send(4'h1, 8'hFF);
        q("full mask", 4'h2, 16'h00FF);
        exec_idle_in = 1'b0;
        ctl.send(4'h9, 8'h00);
        q("pending completion", 4'h0, 16'h0000);
        exec_idle_in = 1'b1;
        @(negedge mclk_in);
        q("completion", 4'h0, 16'h0001);
        $display("test events done");
        for (int i = 0; i < 17; i++) pulse(8'h00, 1'b1, 16'hFF00 | 16'(i));
        check("queue flag", status_byte_out[2], 1'b1);
        q("overflow event", 4'h0, 16'h0008);
        for (int i = 0; i < 16; i++) q("error entry", 4'h8, 16'hFF00 | 16'(i));
        q("drained queue", 4'h8, 16'h0000, 1'b1);
        check("queue flag clear", status_byte_out[2], 1'b0);
        $display("test error queue done");
        print_verdict();
    end
endmodule // tb
